// ===== dv/mic_core_model.sv
// core model: ready level and handler return pulse
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bench commands
   input wire logic hold,
   input wire logic ret_cmd,
   // towards the controller
   output logic core_ready,
   output logic reti
);
   // hold makes the core answer slowly
   assign core_ready = !hold;
   // return pulse one cycle after the command, never during reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         reti <= 1'b0;
      else
         reti <= ret_cmd;
   end
endmodule
`default_nettype wire

// ===== dv/mic_top_props.sv
// assertion checker for the interrupt controller top ports
`timescale 1ns/1ps
`default_nettype none
module mic_top_chk (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // core side
   input wire logic osc_fail,
   input wire logic core_ready,
   input wire logic reti,
   input wire logic pc_load,
   input wire logic [15:0] pc_vector,
   input wire logic [3:0] level_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // ------------------------------------------------------------
   // acknowledge timing
   // ------------------------------------------------------------
   property p_reti_block;
      ce && reti |=> !pc_load;
   endproperty
   a_reti_block: assert property (p_reti_block)
      else $error("ack during handler return");
   property p_not_ready;
      ce && !core_ready |=> !pc_load;
   endproperty
   a_not_ready: assert property (p_not_ready)
      else $error("ack while core not ready");
   property p_nmi_take;
      ce && $rose(osc_fail) && core_ready && !reti && !level_active[3]
         |=> pc_load && level_active[3];
   endproperty
   a_nmi_take: assert property (p_nmi_take)
      else $error("oscillator failure not taken");
   // bits above 11 only carry the boot relocation
   property p_vec_map;
      pc_load |-> (pc_vector & 16'h0FFF) inside {16'h0002, 16'h0004,
         16'h0006, 16'h000C, 16'h000E, 16'h0014, 16'h0016, 16'h0030,
         16'h0048};
   endproperty
   a_vec_map: assert property (p_vec_map)
      else $error("vector outside table");
   // a new handler must sit above every running one
   property p_raise;
      pc_load |-> (level_active & ~$past(level_active))
         > $past(level_active);
   endproperty
   a_raise: assert property (p_raise)
      else $error("ack without preemption right");
   property p_ret_drop;
      ce && reti && level_active != 4'h0 |=>
         $onehot($past(level_active) & ~level_active) &&
         (($past(level_active) & ~level_active) > level_active);
   endproperty
   a_ret_drop: assert property (p_ret_drop)
      else $error("return did not drop the top level");
   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   property p_apb_wait;
      ce && psel && penable && !pready |=> pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("apb answer late");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside answer");
   // main scenarios
   c_nmi: cover property (pc_load && level_active[3]);
   c_nest: cover property (level_active == 4'h7);
   c_ret: cover property (reti && level_active[2]);
endmodule
bind mic_top mic_top_chk i_mic_top_chk (.clk, .arst_n, .ce, .psel,
   .penable, .prdata, .pready, .osc_fail, .core_ready, .reti, .pc_load,
   .pc_vector, .level_active);
`default_nettype wire

// ===== dv/multilevel_interrupt_priority_tb.sv
// self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module multilevel_interrupt_priority_tb;
   import mic_pkg::*;
   logic clk = '0, arst_n = '0, ce = '1, psel = '0, penable = '0;
   logic pwrite = '0, pready, pslverr, err, osc_fail = '0, glob_en = '1;
   logic hold = '0, ret_cmd = '0, core_ready, reti, pc_load, irq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0] src_cond = '0;
   logic [15:0] pc_vector;
   logic [3:0] level_active;
   int n_errors = 0, comparisons = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   mic_top i_mic_top (.clk, .arst_n, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .src_cond, .osc_fail,
      .core_ready, .glob_en, .reti, .pc_load, .pc_vector, .level_active,
      .irq);
   mic_core_model i_mic_core_model (.clk, .arst_n, .hold, .ret_cmd,
      .core_ready, .reti);
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= '1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= '1;
      // only the watchdog ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= '0;
      penable <= '0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb('0, a, '0);
      chk(rd, e);
   endtask
   // outputs sampled at the falling edge, clear of the update
   task automatic ack(input logic [15:0] v, input logic [3:0] act);
      int n;
      n = 0;
      @(negedge clk);
      while (pc_load !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(pc_load, 1);
      chk(pc_vector, v);
      chk(level_active, act);
   endtask
   task automatic ret(input logic [3:0] act);
      @(posedge clk);
      ret_cmd <= '1;
      @(posedge clk);
      ret_cmd <= '0;
      repeat (2) @(negedge clk);
      chk(level_active, act);
   endtask
   task automatic idle(input logic [3:0] act);
      repeat (6) @(negedge clk);
      chk(level_active, act);
   endtask
   task automatic ichk(input logic e);
      repeat (2) @(negedge clk);
      chk(irq, e);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_regs;
      chk(pc_vector, 32'h0);
      chk(irq, 0);
      rdchk(12'h000, 32'h0);
      rdchk(12'h008, 32'h0);
      apb('1, 12'h004, 32'hFF);
      apb('1, 12'h008, 32'h5CA5);
      rdchk(12'h008, 32'h5CA5);
      apb('1, 12'h000, 32'h1C);
      apb('1, 12'h018, 32'hF);
      apb('1, 12'h01C, 32'h1);
      chk(err, 1);
      rdchk(12'h01C, 32'h0);
      chk(err, 1);
      $display("register test done");
   endtask
   task t_nest;
      @(posedge clk) src_cond <= 8'h01;
      ack(16'h0004, 4'h1);
      @(posedge clk) src_cond <= 8'h0A;
      ack(16'h000E, 4'h3);
      @(posedge clk) src_cond <= 8'h26;
      ack(16'h0016, 4'h7);
      @(posedge clk) src_cond <= 8'h06;
      idle(4'h7);
      ret(4'h3);
      ret(4'h1);
      ack(16'h000C, 4'h3);
      @(posedge clk) src_cond <= 8'h02;
      ret(4'h1);
      ret(4'h0);
      ack(16'h0006, 4'h1);
      @(posedge clk) src_cond <= 8'h00;
      ret(4'h0);
      $display("nesting test done");
   endtask
   // slow core first, then two medium sources at once
   task t_same;
      @(posedge clk) hold <= '1;
      @(posedge clk) src_cond <= 8'h1C;
      rdchk(12'h010, 32'h0C);
      chk(level_active, 4'h0);
      @(posedge clk) hold <= '0;
      ack(16'h000C, 4'h2);
      @(posedge clk) src_cond <= 8'h18;
      ret(4'h0);
      ack(16'h000E, 4'h2);
      @(posedge clk) src_cond <= 8'h00;
      ret(4'h0);
      $display("same level test done");
   endtask
   // clock enable low freezes arbitration, then the request is taken
   task t_freeze;
      @(posedge clk) ce <= '0;
      @(posedge clk) src_cond <= 8'h04;
      idle(4'h0);
      chk(pc_load, 0);
      @(posedge clk) ce <= '1;
      ack(16'h000C, 4'h2);
      @(posedge clk) src_cond <= 8'h00;
      ret(4'h0);
      $display("clock enable test done");
   endtask
   task t_rr;
      apb('1, 12'h000, 32'h1D);
      @(posedge clk) src_cond <= 8'hC0;
      ack(16'h0030, 4'h1);
      ret(4'h0);
      ack(16'h0048, 4'h1);
      ret(4'h0);
      ack(16'h0030, 4'h1);
      apb('1, 12'h000, 32'h1C);
      ret(4'h0);
      ack(16'h0030, 4'h1);
      @(posedge clk) src_cond <= 8'h00;
      ret(4'h0);
      apb('1, 12'h000, 32'h1E);
      @(posedge clk) src_cond <= 8'h80;
      ack(16'hF048, 4'h1);
      @(posedge clk) src_cond <= 8'h00;
      ret(4'h0);
      $display("round robin and boot test done");
   endtask
   // maskable paths closed, oscillator failure still served
   task t_nmi;
      apb('1, 12'h000, 32'h0);
      apb('1, 12'h014, 32'hF);
      ichk(0);
      @(posedge clk) src_cond <= 8'h20;
      idle(4'h0);
      @(posedge clk) glob_en <= '0;
      apb('1, 12'h000, 32'h1C);
      idle(4'h0);
      @(posedge clk) osc_fail <= '1;
      ack(16'h0002, 4'h8);
      ichk(1);
      rdchk(12'h014, 32'h8);
      apb('1, 12'h018, 32'h0);
      ichk(0);
      ret(4'h0);
      idle(4'h0);
      @(posedge clk) osc_fail <= '0;
      apb('1, 12'h018, 32'hF);
      ichk(1);
      apb('1, 12'h014, 32'hF);
      ichk(0);
      $display("non-maskable test done");
   endtask
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= '1;
      t_regs;
      t_nest;
      t_same;
      t_freeze;
      t_rr;
      t_nmi;
      complete_run;
   end
   // the tests need well under 2000 cycles
   initial begin
      #20000;
      n_errors++;
      complete_run;
   end
endmodule
`default_nettype wire

// ===== rtl/mic_arbiter.sv
// one level of arbitration: fixed lowest index or round robin
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"
module mic_arbiter
   import mic_pkg::*;
(
   // requests of this level
   input wire logic [`MIC_NSRC-1:0] req,
   // round robin control
   input wire logic rr_en,
   input wire logic [`MIC_IDX_W-1:0] rr_last,
   // winner
   output logic valid,
   output logic [`MIC_IDX_W-1:0] idx
);

   // first set bit at or after start, wrapping round
   function automatic logic [`MIC_IDX_W:0] first_from(
      input logic [`MIC_NSRC-1:0] r,
      input logic [`MIC_IDX_W-1:0] start
   );
      logic [`MIC_IDX_W:0] res;
      logic [`MIC_IDX_W-1:0] k;
      res = '0;
      for (int n = `MIC_NSRC - 1; n >= 0; n--) begin
         k = start + n[`MIC_IDX_W-1:0];
         if (r[k]) begin
            res = {1'b1, k};
         end
      end
      return res;
   endfunction

   logic [`MIC_IDX_W:0] pick;
   logic [`MIC_IDX_W-1:0] start;

   // table is sorted by address, so index 0 is the lowest vector
   always_comb begin
      start = rr_en ? rr_last + 3'h1 : 3'h0;
      pick = first_from(req, start);
      valid = pick[`MIC_IDX_W];
      idx = pick[`MIC_IDX_W-1:0];
   end

endmodule
`default_nettype wire

// ===== rtl/mic_params.svh
// constants for the multilevel interrupt controller
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define MIC_NSRC 8
`define MIC_IDX_W 3
`define MIC_VEC_W 16
`define MIC_ADDR_W 12

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define MIC_CTRL_OFS 12'h000
`define MIC_SRCEN_OFS 12'h004
`define MIC_LEVEL_OFS 12'h008
`define MIC_ACTIVE_OFS 12'h00C
`define MIC_PEND_OFS 12'h010
`define MIC_ISTS_OFS 12'h014
`define MIC_IMSK_OFS 12'h018

// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define MIC_CTRL_RR_BIT 0
`define MIC_CTRL_BOOT_BIT 1
`define MIC_CTRL_LOEN_BIT 2
`define MIC_CTRL_W 5
`define MIC_CTRL_RST 5'h00
`define MIC_SRCEN_RST 8'h00
`define MIC_LEVEL_RST 16'h0000
`define MIC_ACT_W 4
`define MIC_ACT_NMI_BIT 3
`define MIC_ISTS_W 4
`define MIC_ISTS_NMI_BIT 3

// ------------------------------------------------------------
// vector table, word addresses
// ------------------------------------------------------------
`define MIC_RESET_VEC 16'h0000
`define MIC_OSCF_VEC 16'h0002
`define MIC_PORTC_BASE 16'h0004
`define MIC_DMA_BASE 16'h000C
`define MIC_RTC_BASE 16'h0014
`define MIC_SPIC_VEC 16'h0030
`define MIC_AES_VEC 16'h0048
`define MIC_SUB_OFS 16'h0002
`define MIC_BOOT_BASE 16'hF000

`endif

// ===== rtl/mic_pkg.sv
// types shared by the interrupt controller modules
package mic_pkg;
`include "mic_params.svh"

   // priority level of one source
   typedef enum logic [1:0] {
      LVL_OFF,
      LVL_LO,
      LVL_MED,
      LVL_HI
   } mic_lvl_type;

   // whole state of the top module
   typedef struct packed {
      logic [`MIC_CTRL_W-1:0] ctrl;
      logic [`MIC_NSRC-1:0] src_en;
      logic [2*`MIC_NSRC-1:0] level;
      logic [`MIC_ACT_W-1:0] active;
      logic [`MIC_IDX_W-1:0] rr_last;
      logic nmi_seen;
      logic [`MIC_ISTS_W-1:0] ists;
      logic [`MIC_ISTS_W-1:0] imsk;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic pc_load;
      logic [`MIC_VEC_W-1:0] pc_vec;
      logic irq;
   } mic_state_type;
endpackage

// ===== rtl/mic_top.sv
// multilevel interrupt controller with apb registers
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"

// Summary of operation
// - every source has its own two-bit level: off, low, medium or high.
// - a pending medium request preempts a running low handler.
// - a pending high request preempts a running medium or low handler.
// - within one level the source with the smallest vector wins.
// - low level can use round robin so every low source gets served.
// - non-maskable requests ignore level enables and the global enable.
// - oscillator failure is non-maskable and vectors to word two.
// - a vector is the peripheral base plus the interrupt offset.
// - on acknowledge the program counter is loaded with the vector.
// - a source requests only when enabled, levelled and its cause holds.
// - vectors are word addresses with reset at word zero.
// - the table moves to the boot section under a control bit.
// - single-interrupt peripherals use one fixed vector.
// - multi-interrupt peripherals use fixed base addresses.
module mic_top
   import mic_pkg::*;
#(
   parameter logic [`MIC_VEC_W-1:0] BOOT_BASE = `MIC_BOOT_BASE
)
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`MIC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral interrupt causes
   input wire logic [`MIC_NSRC-1:0] src_cond,
   input wire logic osc_fail,
   // processor core
   input wire logic core_ready,
   input wire logic glob_en,
   input wire logic reti,
   output logic pc_load,
   output logic [`MIC_VEC_W-1:0] pc_vector,
   output logic [`MIC_ACT_W-1:0] level_active,
   // interrupt to system
   output logic irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mic_state_type s_r;
   mic_state_type s_nxt;

   logic [`MIC_NSRC-1:0] req_all;
   logic [`MIC_NSRC-1:0] req_lvl [3];
   logic lvl_valid [3];
   logic [`MIC_IDX_W-1:0] lvl_idx [3];
   logic [`MIC_IDX_W-1:0] sel_idx;
   logic sel_nmi;
   logic [`MIC_VEC_W-1:0] sel_vec;

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // level code of one source
   function automatic mic_lvl_type lvl_of(
      input logic [2*`MIC_NSRC-1:0] lv,
      input int i
   );
      return mic_lvl_type'(lv[2*i +: 2]);
   endfunction

   // a level may start only while nothing at or above it runs
   function automatic logic lvl_free(
      input logic [`MIC_ACT_W-1:0] act,
      input int l
   );
      logic is_free;
      is_free = 1'b1;
      for (int k = l; k < `MIC_ACT_W; k++) begin
         if (act[k]) begin
            is_free = 1'b0;
         end
      end
      return is_free;
   endfunction

   // one-hot register select, shared by read mux and write path
   function automatic logic [6:0] reg_sel(
      input logic [`MIC_ADDR_W-1:0] a
   );
      logic [6:0] sel;
      sel[0] = (a == `MIC_CTRL_OFS);
      sel[1] = (a == `MIC_SRCEN_OFS);
      sel[2] = (a == `MIC_LEVEL_OFS);
      sel[3] = (a == `MIC_ACTIVE_OFS);
      sel[4] = (a == `MIC_PEND_OFS);
      sel[5] = (a == `MIC_ISTS_OFS);
      sel[6] = (a == `MIC_IMSK_OFS);
      return sel;
   endfunction

   // ------------------------------------------------------------
   // request qualification per level
   // ------------------------------------------------------------
   genvar gl;
   genvar gi;
   generate
      for (gi = 0; gi < `MIC_NSRC; gi++) begin : g_req
         // enabled, levelled and cause present
         assign req_all[gi] = s_r.src_en[gi] & src_cond[gi] &
            (lvl_of(s_r.level, gi) != LVL_OFF);
      end
      for (gl = 0; gl < 3; gl++) begin : g_lvl
         for (gi = 0; gi < `MIC_NSRC; gi++) begin : g_bit
            assign req_lvl[gl][gi] = req_all[gi] &
               s_r.ctrl[`MIC_CTRL_LOEN_BIT + gl] &
               (lvl_of(s_r.level, gi) == mic_lvl_type'(gl + 1));
         end
         // round robin only makes sense for the low level
         mic_arbiter u_arb (
            .req(req_lvl[gl]),
            .rr_en((gl == 0) && s_r.ctrl[`MIC_CTRL_RR_BIT]),
            .rr_last(s_r.rr_last),
            .valid(lvl_valid[gl]),
            .idx(lvl_idx[gl])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // vector formation
   // ------------------------------------------------------------
   // nmi overrides the index inside the vector block
   mic_vector #(
      .BOOT_BASE(BOOT_BASE)
   ) u_vec (
      .nmi(sel_nmi),
      .idx(sel_idx),
      .boot_sel(s_r.ctrl[`MIC_CTRL_BOOT_BIT]),
      .vector(sel_vec)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic ack;
   logic [1:0] ack_lvl;
   logic apb_wr;
   logic apb_rd;
   logic [`MIC_ISTS_W-1:0] ev;
   logic [31:0] rdata;
   logic hit;
   logic [6:0] rsel;

   always_comb begin
      s_nxt = s_r;
      ack = 1'b0;
      ack_lvl = 2'h0;
      sel_nmi = 1'b0;
      sel_idx = lvl_idx[0];
      ev = '0;

      // release of the nmi latch once the cause is gone
      if (!osc_fail) begin
         s_nxt.nmi_seen = 1'b0;
      end

      // return unwinds the highest active level first
      if (reti) begin
         if (s_r.active[3]) begin
            s_nxt.active[3] = 1'b0;
         end else if (s_r.active[2]) begin
            s_nxt.active[2] = 1'b0;
         end else if (s_r.active[1]) begin
            s_nxt.active[1] = 1'b0;
         end else begin
            s_nxt.active[0] = 1'b0;
         end
      end else if (core_ready) begin
         // nmi ignores level enables and global enable
         if (osc_fail && !s_r.nmi_seen && lvl_free(s_r.active, 3)) begin
            ack = 1'b1;
            sel_nmi = 1'b1;
            s_nxt.nmi_seen = 1'b1;
            s_nxt.active[3] = 1'b1;
            ev[`MIC_ISTS_NMI_BIT] = 1'b1;
         end else if (glob_en && lvl_valid[2] &&
                      lvl_free(s_r.active, 2)) begin
            ack = 1'b1;
            ack_lvl = 2'h2;
            sel_idx = lvl_idx[2];
         end else if (glob_en && lvl_valid[1] &&
                      lvl_free(s_r.active, 1)) begin
            ack = 1'b1;
            ack_lvl = 2'h1;
            sel_idx = lvl_idx[1];
         end else if (glob_en && lvl_valid[0] &&
                      lvl_free(s_r.active, 0)) begin
            ack = 1'b1;
            sel_idx = lvl_idx[0];
            s_nxt.rr_last = lvl_idx[0];
         end
         if (ack && !sel_nmi) begin
            s_nxt.active[ack_lvl] = 1'b1;
            ev[ack_lvl] = 1'b1;
         end
      end

      // program counter load, one cycle pulse
      s_nxt.pc_load = ack;
      if (ack) begin
         s_nxt.pc_vec = sel_vec;
      end

      // apb: one wait state, answer from flops; the read mux is
      // registered so prdata never ripples straight from paddr
      apb_rd = 1'b0;
      apb_wr = psel && penable && s_r.pready && pwrite;
      rsel = reg_sel(paddr);
      hit = |rsel;
      unique case (1'b1)
         rsel[0]: rdata = {27'h0, s_r.ctrl};
         rsel[1]: rdata = {24'h0, s_r.src_en};
         rsel[2]: rdata = {16'h0, s_r.level};
         rsel[3]: rdata = {28'h0, s_r.active};
         rsel[4]: rdata = {24'h0, req_all};
         rsel[5]: rdata = {28'h0, s_r.ists};
         rsel[6]: rdata = {28'h0, s_r.imsk};
         default: rdata = 32'h0000_0000;
      endcase
      s_nxt.pready = psel && penable && !s_r.pready;
      if (psel && penable && !s_r.pready) begin
         apb_rd = !pwrite;
         s_nxt.pslverr = !hit;
         s_nxt.prdata = apb_rd ? rdata : 32'h0000_0000;
      end else begin
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata = 32'h0000_0000;
      end

      // register writes at the completing edge
      if (apb_wr) begin
         unique case (1'b1)
            rsel[0]: s_nxt.ctrl = pwdata[`MIC_CTRL_W-1:0];
            rsel[1]: s_nxt.src_en = pwdata[`MIC_NSRC-1:0];
            rsel[2]: s_nxt.level = pwdata[2*`MIC_NSRC-1:0];
            rsel[5]: s_nxt.ists = s_r.ists &
               ~pwdata[`MIC_ISTS_W-1:0];
            rsel[6]: s_nxt.imsk = pwdata[`MIC_ISTS_W-1:0];
            default: s_nxt.ctrl = s_r.ctrl;
         endcase
      end

      // sticky events; a set in the clear cycle wins
      s_nxt.ists = s_nxt.ists | ev;
      s_nxt.irq = |(s_nxt.ists & s_nxt.imsk);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // all state freezes while ce is low
   // apb freezes too, so a master must not start a transfer then
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r.ctrl <= `MIC_CTRL_RST;
         s_r.src_en <= `MIC_SRCEN_RST;
         s_r.level <= `MIC_LEVEL_RST;
         s_r.active <= '0;
         s_r.rr_last <= '1;
         s_r.nmi_seen <= 1'b0;
         s_r.ists <= '0;
         s_r.imsk <= '0;
         s_r.pready <= 1'b0;
         s_r.pslverr <= 1'b0;
         s_r.prdata <= 32'h0000_0000;
         s_r.pc_load <= 1'b0;
         s_r.pc_vec <= `MIC_RESET_VEC;
         s_r.irq <= 1'b0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs, all straight from flops
   // ------------------------------------------------------------
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign pc_load = s_r.pc_load;
   assign pc_vector = s_r.pc_vec;
   assign level_active = s_r.active;
   assign irq = s_r.irq;

endmodule
`default_nettype wire

// ===== rtl/mic_vector.sv
// vector formation from base address plus offset
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"
module mic_vector
   import mic_pkg::*;
#(
   parameter logic [`MIC_VEC_W-1:0] BOOT_BASE = `MIC_BOOT_BASE
)
(
   // selection
   input wire logic nmi,
   input wire logic [`MIC_IDX_W-1:0] idx,
   input wire logic boot_sel,
   // result
   output logic [`MIC_VEC_W-1:0] vector
);

   logic [`MIC_VEC_W-1:0] rel;

   // word addresses relative to the table start
   always_comb begin
      unique case (idx)
         3'h0: rel = `MIC_PORTC_BASE;
         3'h1: rel = `MIC_PORTC_BASE + `MIC_SUB_OFS;
         3'h2: rel = `MIC_DMA_BASE;
         3'h3: rel = `MIC_DMA_BASE + `MIC_SUB_OFS;
         3'h4: rel = `MIC_RTC_BASE;
         3'h5: rel = `MIC_RTC_BASE + `MIC_SUB_OFS;
         3'h6: rel = `MIC_SPIC_VEC;
         3'h7: rel = `MIC_AES_VEC;
      endcase
      if (nmi) begin
         rel = `MIC_OSCF_VEC;
      end
      // relocation between application and boot section
      vector = (boot_sel ? BOOT_BASE : `MIC_RESET_VEC) + rel;
   end

endmodule
`default_nettype wire
